// ===== src/tmrcc_pkg.sv
/*
 * Package for the timer/counter control interface: register offsets,
 * field positions, reset values, codes and the packed carriers.
 * Assumes a 32-bit AXI4-Lite register bus and a single core clock.
 */
`default_nettype none
package tmrcc_pkg;
	// Block layout: two blocks of three channels, channel window of 64 bytes.
	localparam int NUM_BLOCKS = 2;
	localparam int CH_PER_BLOCK = 3;
	localparam int NUM_CH = NUM_BLOCKS * CH_PER_BLOCK;
	localparam logic [31:0] BLOCK0_BASE_DEF = 32'hFFFD0000;
	localparam logic [31:0] BLOCK1_BASE_DEF = 32'hFFFD4000;
	localparam logic [1:0] BLOCK_REG_WIN = 2'h3;
	// Channel register offsets, relative to the channel window.
	localparam logic [7:0] OFF_CCR = 8'h00;
	localparam logic [7:0] OFF_CMR = 8'h04;
	localparam logic [7:0] OFF_CV = 8'h10;
	localparam logic [7:0] OFF_RA = 8'h14;
	localparam logic [7:0] OFF_RB = 8'h18;
	localparam logic [7:0] OFF_RC = 8'h1C;
	localparam logic [7:0] OFF_SR = 8'h20;
	localparam logic [7:0] OFF_IER = 8'h24;
	localparam logic [7:0] OFF_IDR = 8'h28;
	localparam logic [7:0] OFF_IMR = 8'h2C;
	// Block register offsets.
	localparam logic [7:0] OFF_BCR = 8'hC0;
	localparam logic [7:0] OFF_BMR = 8'hC4;
	// Command bits.
	localparam int CMD_CLK_ON = 0;
	localparam int CMD_CLK_OFF = 1;
	localparam int CMD_SOFT_TRIG = 2;
	localparam int BCR_SYNC = 0;
	// Channel mode fields.
	localparam int CMR_CLKS = 0;
	localparam int CMR_EDGE_INV = 3;
	localparam int CMR_BURST = 4;
	localparam int CMR_STOP_ON_B = 6;
	localparam int CMR_DIS_ON_B = 7;
	localparam int CMR_TRIG_EDGE = 8;
	localparam int CMR_TRIG_LINE = 10;
	localparam int CMR_PERIOD_TRIG = 14;
	localparam int CMR_WAVE = 15;
	localparam int CMR_FIRST_LOAD = 16;
	localparam int CMR_SECOND_LOAD = 18;
	localparam logic [31:0] CMR_RST = 32'h00000000;
	// Block routing register: three 2-bit fields.
	localparam int BMR_W = 6;
	localparam logic [5:0] BMR_RST = 6'h00;
	localparam logic [1:0] ROUTE_PIN = 2'h0;
	localparam logic [1:0] ROUTE_NONE = 2'h1;
	localparam logic [1:0] ROUTE_LOW = 2'h2;
	localparam logic [1:0] ROUTE_HIGH = 2'h3;
	// Prescaler taps for master clock divided by 2, 8, 32, 128 and 1024.
	localparam int PRE_W = 10;
	localparam int DIV2_BIT = 0;
	localparam int DIV8_BIT = 2;
	localparam int DIV32_BIT = 4;
	localparam int DIV128_BIT = 6;
	localparam int DIV1024_BIT = 9;
	// Edge codes.
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	// Status bit of the clock enable state.
	localparam int SR_CLKSTA = 16;
	localparam int FLAG_W = 6;
	localparam logic [15:0] CV_MAX = 16'hFFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decoded bus address.
	typedef struct packed {
		logic hit;
		logic blk;
		logic [1:0] ch;
		logic [7:0] off;
		logic [7:0] roff;
	} tmrcc_addr_t;

	// Sticky status flags, low six bits of the status word.
	typedef struct packed {
		logic etrgs;
		logic ldrbs;
		logic ldras;
		logic cpcs;
		logic ovrun;
		logic covfs;
	} tmrcc_flags_t;
endpackage : tmrcc_pkg
`default_nettype wire

// ===== src/tmrcc_top.sv
/*
 * Two timer blocks of three 16-bit capture channels behind an AXI4-Lite
 * slave: block sync command, clock routing, channel commands, clock
 * selection, gating, triggers, capture loads and sticky status.
 * Assumes all pins are synchronous to core_clk and that the bus master
 * keeps at most one write and one read under way.
 */
`default_nettype none
// Operation
// - Two blocks, each decoded from own base
// - Channels at 0x00, 0x40, 0x80 in block
// - Block sync bit triggers all three channels
// - Line 0 route: pin0, none, ch1 A, ch2 A
// - Line 1 route: pin1, none, ch0 A, ch2 A
// - Line 2 route: pin2, none, ch0 A, ch1 A
// - Enable bit starts clock unless disable set
// - Disable bit stops the counter clock
// - Software trigger resets counter, starts clock
// - Clock select: five dividers, three external lines
// - Invert bit picks falling counting edge
// - Gating field ANDs clock with external line
// - Second load stops clock when enabled
// - Second load disables clock when enabled
// - Trigger edge: none, rise, fall, both
// - Trigger line: B when zero, A when one
// - Period match triggers when enabled
// - Mode bit picks capture or waveform
// - First load edge field on line A
// - Second load edge field on line A
// - Capture registers read-only in capture mode
// - Every trigger zeroes counter, starts clock
// - Loads alternate first, second, since trigger
// - Unread reload overwrites and flags overrun
module tmrcc_top
	import tmrcc_pkg::*;
#(
	parameter logic [31:0] BLOCK0_BASE = BLOCK0_BASE_DEF,
	parameter logic [31:0] BLOCK1_BASE = BLOCK1_BASE_DEF
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rstn,
	// AXI4-Lite write channels.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins, index is block * 3 + channel.
	input wire logic [5:0] clock_pin,
	input wire logic [5:0] io_line_a,
	input wire logic [5:0] io_line_b
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Decodes a byte address into block, channel window and offset.
	function automatic tmrcc_addr_t decode(input logic [31:0] a);
		tmrcc_addr_t d;
		d.blk = (a[31:8] == BLOCK1_BASE[31:8]);
		d.ch = a[7:6];
		d.off = {a[7:2], 2'b00};
		d.roff = {2'b00, a[5:2], 2'b00};
		d.hit = (d.blk || (a[31:8] == BLOCK0_BASE[31:8]))
			&& (d.ch != BLOCK_REG_WIN || a[5:3] == 3'h0);
		return d;
	endfunction : decode

	// Merges write data into an old value under the byte strobes.
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : wmask

	// Edge code bit 0 takes rising edges, bit 1 falling edges.
	function automatic logic edge_hit(input logic [1:0] code, input logic prev,
			input logic cur);
		return (code[0] & !prev & cur) | (code[1] & prev & !cur);
	endfunction : edge_hit

	// Level of the selected counting clock.
	function automatic logic clk_level(input logic [2:0] sel, input logic [PRE_W-1:0] pre,
			input logic [2:0] x);
		unique case (sel)
			3'h0: return pre[DIV2_BIT];
			3'h1: return pre[DIV8_BIT];
			3'h2: return pre[DIV32_BIT];
			3'h3: return pre[DIV128_BIT];
			3'h4: return pre[DIV1024_BIT];
			3'h5: return x[0];
			3'h6: return x[1];
			3'h7: return x[2];
		endcase
	endfunction : clk_level

	// Gate term: open for code 0, else the chosen external line.
	function automatic logic gate_ok(input logic [1:0] code, input logic [2:0] x);
		unique case (code)
			2'h0: return 1'b1;
			2'h1: return x[0];
			2'h2: return x[1];
			2'h3: return x[2];
		endcase
	endfunction : gate_ok

	// Routes one external clock line from its four sources.
	function automatic logic route(input logic [1:0] code, input logic pin,
			input logic lo, input logic hi);
		unique case (code)
			ROUTE_PIN: return pin;
			ROUTE_NONE: return 1'b0;
			ROUTE_LOW: return lo;
			ROUTE_HIGH: return hi;
		endcase
	endfunction : route

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	logic aw_full;
	logic w_full;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic rd_go;
	tmrcc_addr_t wd;
	tmrcc_addr_t rdd;
	logic [31:0] rd_word;

	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wd = decode(aw_addr);
	assign rdd = decode(s_axi_araddr);

	// Address and data are held separately so either may come first.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end else if (!aw_full && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (wr_go) begin
				w_full <= 1'b0;
			end else if (!w_full && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response; addresses outside both blocks answer SLVERR.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wd.hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel; data is sampled at the address handshake.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rdd.hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid) begin
			s_axi_rvalid <= !s_axi_rready;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared state and block registers.

	logic [PRE_W-1:0] pre;
	logic [BMR_W-1:0] bmr [NUM_BLOCKS];
	logic [NUM_BLOCKS-1:0][2:0] xc;
	logic [NUM_BLOCKS-1:0] sync;
	logic [31:0] mode [NUM_CH];
	logic [15:0] cv [NUM_CH];
	logic [15:0] ra [NUM_CH];
	logic [15:0] rb [NUM_CH];
	logic [15:0] rc [NUM_CH];
	tmrcc_flags_t flg [NUM_CH];
	logic [FLAG_W-1:0] imr [NUM_CH];
	logic [NUM_CH-1:0] en, run, wait_b, trig, lda, ldb, cnt, rc_hit, etrg;
	logic [NUM_CH-1:0] wsel, rsel;

	// Free-running prescaler; its taps are the divided master clocks.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pre <= '0;
		end else begin
			pre <= pre + PRE_W'(1);
		end
	end

	for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
		logic bsel;
		assign bsel = wr_go && wd.hit && wd.blk == 1'(b) && wd.ch == BLOCK_REG_WIN;
		// The sync bit acts only in its write cycle and holds no state.
		assign sync[b] = bsel && wd.off == OFF_BCR && w_strb[0]
			&& w_data[BCR_SYNC];

		// Routing register.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				bmr[b] <= BMR_RST;
			end else if (bsel && wd.off == OFF_BMR) begin
				bmr[b] <= BMR_W'(wmask(32'(bmr[b]), w_data, w_strb));
			end
		end

		// Each line picks its pin or the A line of one of two other channels.
		for (genvar k = 0; k < CH_PER_BLOCK; k++) begin : g_line
			localparam int LO = (k == 0) ? 1 : 0;
			localparam int HI = (k == 2) ? 1 : 2;
			assign xc[b][k] = route(bmr[b][2*k +: 2], clock_pin[b*3+k],
				io_line_a[b*3+LO], io_line_a[b*3+HI]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channels.

	for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
		localparam int B = i / CH_PER_BLOCK;
		logic [31:0] m;
		logic cap, lvl, lvl_prev, ext, ext_prev, a_prev, ccr, soft_trig, ovr, st_rd;
		logic [FLAG_W-1:0] set, clr;

		assign wsel[i] = wr_go && wd.hit && wd.blk == 1'(B)
			&& wd.ch == 2'(i % CH_PER_BLOCK);
		assign rsel[i] = rd_go && rdd.hit && rdd.blk == 1'(B)
			&& rdd.ch == 2'(i % CH_PER_BLOCK);
		assign m = mode[i];
		assign cap = !m[CMR_WAVE];
		assign ccr = wsel[i] && wd.roff == OFF_CCR && w_strb[0];
		assign soft_trig = ccr && w_data[CMD_SOFT_TRIG];
		// Selected, gated clock; counted on the edge the invert bit names.
		assign lvl = clk_level(m[CMR_CLKS +: 3], pre, xc[B])
			& gate_ok(m[CMR_BURST +: 2], xc[B]);
		// A second load that stops or disables the clock also swallows a count in
		// its own cycle, so the counter keeps the value captured in B.
		assign cnt[i] = en[i] && run[i]
			&& !(ldb[i] && (m[CMR_STOP_ON_B] || m[CMR_DIS_ON_B]))
			&& edge_hit(m[CMR_EDGE_INV] ? EDGE_FALL : EDGE_RISE, lvl_prev, lvl);
		assign rc_hit[i] = cnt[i] && cv[i] == rc[i];
		assign ext = m[CMR_TRIG_LINE] ? io_line_a[i] : io_line_b[i];
		assign etrg[i] = cap && edge_hit(m[CMR_TRIG_EDGE +: 2], ext_prev, ext);
		// Loads alternate: A waits for B and B waits for A.
		assign lda[i] = cap && !wait_b[i]
			&& edge_hit(m[CMR_FIRST_LOAD +: 2], a_prev, io_line_a[i]);
		assign ldb[i] = cap && wait_b[i]
			&& edge_hit(m[CMR_SECOND_LOAD +: 2], a_prev, io_line_a[i]);
		assign trig[i] = soft_trig || sync[B] || etrg[i]
			|| (rc_hit[i] && m[CMR_PERIOD_TRIG]);

		// Sampled history for edge detection; pins are already synchronous.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				lvl_prev <= 1'b0;
				ext_prev <= 1'b0;
				a_prev <= 1'b0;
			end else begin
				lvl_prev <= lvl;
				ext_prev <= ext;
				a_prev <= io_line_a[i];
			end
		end

		// Clock enable: disable, by command or second load, wins over enable.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				en[i] <= 1'b0;
			end else if ((ccr && w_data[CMD_CLK_OFF])
					|| (ldb[i] && m[CMR_DIS_ON_B])) begin
				en[i] <= 1'b0;
			end else if (ccr && w_data[CMD_CLK_ON]) begin
				en[i] <= 1'b1;
			end
		end

		// Run state: a trigger starts the clock, a second load may stop it.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				run[i] <= 1'b0;
			end else if (trig[i]) begin
				run[i] <= 1'b1;
			end else if (ldb[i] && m[CMR_STOP_ON_B]) begin
				run[i] <= 1'b0;
			end
		end

		// Counter; it wraps at the top and flags the overflow.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				cv[i] <= 16'h0000;
			end else if (trig[i]) begin
				cv[i] <= 16'h0000;
			end else if (cnt[i]) begin
				cv[i] <= cv[i] + 16'h0001;
			end
		end

		// Load sequencing, reset by any trigger.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				wait_b[i] <= 1'b0;
			end else if (trig[i]) begin
				wait_b[i] <= 1'b0;
			end else if (lda[i]) begin
				wait_b[i] <= 1'b1;
			end else if (ldb[i]) begin
				wait_b[i] <= 1'b0;
			end
		end

		// Mode and compare registers; A and B take software data only in
		// waveform mode, so a capture cannot be clobbered by a stray write.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				mode[i] <= CMR_RST;
				ra[i] <= 16'h0000;
				rb[i] <= 16'h0000;
				rc[i] <= 16'h0000;
			end else begin
				if (wsel[i] && wd.roff == OFF_CMR) begin
					mode[i] <= wmask(m, w_data, w_strb);
				end
				if (wsel[i] && wd.roff == OFF_RC) begin
					rc[i] <= 16'(wmask(32'(rc[i]), w_data, w_strb));
				end
				if (lda[i]) begin
					ra[i] <= cv[i];
				end else if (wsel[i] && wd.roff == OFF_RA && !cap) begin
					ra[i] <= 16'(wmask(32'(ra[i]), w_data, w_strb));
				end
				if (ldb[i]) begin
					rb[i] <= cv[i];
				end else if (wsel[i] && wd.roff == OFF_RB && !cap) begin
					rb[i] <= 16'(wmask(32'(rb[i]), w_data, w_strb));
				end
			end
		end

		// Sticky flags: a status read clears all, a read of A or B clears its
		// load flag, and a new event in that cycle still sets its bit.
		assign ovr = (lda[i] && flg[i].ldras) || (ldb[i] && flg[i].ldrbs);
		assign st_rd = rsel[i] && rdd.roff == OFF_SR;
		assign set = {etrg[i], ldb[i], lda[i], rc_hit[i], ovr, cnt[i] && cv[i] == CV_MAX};
		assign clr = st_rd ? {FLAG_W{1'b1}}
			: {1'b0, rsel[i] && rdd.roff == OFF_RB, rsel[i] && rdd.roff == OFF_RA, 3'h0};
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				flg[i] <= '0;
			end else begin
				flg[i] <= tmrcc_flags_t'((flg[i] & ~clr) | set);
			end
		end

		// Interrupt mask, set and cleared through separate write-only words.
		always_ff @(posedge core_clk) begin
			if (!rstn) begin
				imr[i] <= '0;
			end else if (wsel[i] && wd.roff == OFF_IER) begin
				imr[i] <= imr[i] | w_data[FLAG_W-1:0];
			end else if (wsel[i] && wd.roff == OFF_IDR) begin
				imr[i] <= imr[i] & ~w_data[FLAG_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data; write-only and reserved words read as zero.

	always_comb begin
		logic [2:0] ci;
		ci = 3'(rdd.blk) * 3'h3 + 3'(rdd.ch);
		rd_word = 32'h00000000;
		if (rdd.hit && rdd.ch == BLOCK_REG_WIN) begin
			if (rdd.off == OFF_BMR) begin
				rd_word = 32'(bmr[rdd.blk]);
			end
		end else if (rdd.hit) begin
			case (rdd.roff)
				OFF_CMR: rd_word = mode[ci];
				OFF_CV: rd_word = 32'(cv[ci]);
				OFF_RA: rd_word = 32'(ra[ci]);
				OFF_RB: rd_word = 32'(rb[ci]);
				OFF_RC: rd_word = 32'(rc[ci]);
				OFF_SR: rd_word = 32'(flg[ci]) | (32'(en[ci]) << SR_CLKSTA);
				OFF_IMR: rd_word = 32'(imr[ci]);
				default: rd_word = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions on block 0: channel 0, sync of all three channels, line 0 routing; command-word reads on every channel of both blocks.

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	logic soft_trig_w0;
	assign soft_trig_w0 = wsel[0] && wd.roff == OFF_CCR && w_strb[0] && w_data[CMD_SOFT_TRIG];
	property p_soft_trig_clears;
		soft_trig_w0 |=> cv[0] == 16'h0000 && run[0];
	endproperty
	a_soft_trig_clears: assert property (p_soft_trig_clears)
		else $error("soft trigger did not restart");

	property p_sync_all;
		sync[0] |=> cv[0] == 16'h0000 && cv[1] == 16'h0000 && cv[2] == 16'h0000;
	endproperty
	a_sync_all: assert property (p_sync_all) else $error("sync did not reach all channels");

	property p_clk_on;
		wsel[0] && wd.roff == OFF_CCR && w_strb[0] && w_data[CMD_CLK_ON]
			&& !w_data[CMD_CLK_OFF] && !ldb[0] |=> en[0] ##1 en[0] || $past(ldb[0]);
	endproperty
	a_clk_on: assert property (p_clk_on) else $error("enable command lost");

	property p_clk_off;
		wsel[0] && wd.roff == OFF_CCR && w_strb[0] && w_data[CMD_CLK_OFF] |=> !en[0];
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("disable command lost");

	property p_route;
		bmr[0][1:0] == ROUTE_HIGH |-> xc[0][0] == io_line_a[2];
	endproperty
	a_route: assert property (p_route) else $error("line 0 misrouted");

	property p_ra_ro;
		wsel[0] && wd.roff == OFF_RA && !mode[0][CMR_WAVE] && !lda[0] |=> $stable(ra[0]);
	endproperty
	a_ra_ro: assert property (p_ra_ro) else $error("capture register written");

	property p_dis_on_b;
		ldb[0] && mode[0][CMR_DIS_ON_B] |=> !en[0];
	endproperty
	a_dis_on_b: assert property (p_dis_on_b) else $error("second load did not disable");

	property p_ovr;
		lda[0] && flg[0].ldras |=> flg[0].ovrun && ra[0] == $past(cv[0]);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun not flagged");

	property p_alt;
		lda[0] && !trig[0] |=> wait_b[0] && !lda[0];
	endproperty
	a_alt: assert property (p_alt) else $error("load order broken");

	property p_wo_zero;
		rd_go && rdd.hit && rdd.ch != BLOCK_REG_WIN && rdd.roff == OFF_CCR
			|=> s_axi_rvalid && s_axi_rdata == 32'h00000000;
	endproperty
	a_wo_zero: assert property (p_wo_zero) else $error("command word read nonzero");

	c_trig: cover property (trig[0] ##[1:20] cnt[0]);
	c_load_pair: cover property (lda[0] ##[1:200] ldb[0]);
	logic ovr_seen;
	assign ovr_seen = flg[0].ovrun;
	c_overrun: cover property (ovr_seen);
	c_period: cover property (rc_hit[0] && mode[0][CMR_PERIOD_TRIG]);

endmodule : tmrcc_top
`default_nettype wire

// ===== tb/timer_counter_control_interface_test.sv
/*
 * Self-checking bench for the timer/counter control interface.
 * Assumes tmrcc_pkg and tmrcc_top are compiled before this file.
 */
`default_nettype none
module timer_counter_control_interface_test
	import tmrcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	// Bus, pins and bookkeeping; every design input has a value at time zero.
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic [5:0] clock_pin = 6'h0, io_line_a = 6'h0, io_line_b = 6'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] seed = 32'h32;
	logic [31:0] ma [6];
	logic [7:0] zoff [8] = '{OFF_CCR, OFF_CMR, 8'h08, OFF_CV, OFF_RA, OFF_RB, OFF_RC, OFF_IMR};
	logic [1:0] routes [4] = '{ROUTE_PIN, ROUTE_LOW, ROUTE_HIGH, ROUTE_NONE};
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;

	// Strobes are tied full: every register here is one whole word.
	tmrcc_top dut_u (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .clock_pin(clock_pin), .io_line_a(io_line_a),
		.io_line_b(io_line_b));

	// Clock of 40 ns and a cycle ceiling that cuts a hang short.
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Expectation helpers and the repeatable xorshift source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] ad(input int b, input int c, input logic [7:0] off);
		return (b == 1 ? BLOCK1_BASE_DEF : BLOCK0_BASE_DEF) + 32'(c) * 32'h40 + 32'(off);
	endfunction : ad
	// Only the documented capture-mode fields are promised to read back.
	function automatic logic [31:0] mmask(input logic [31:0] d);
		return d & 32'h000FC7FF;
	endfunction : mmask
	// Pulses leave the line high, so rising edges outnumber falling by one.
	function automatic logic [31:0] ext_cnt(input int i, input int k);
		return i >= 2 ? 32'h0 : 32'(i == 0 ? k + 1 : k);
	endfunction : ext_cnt
	////////////////////////////////////////////////////////////////////////
	// Comparison, bus cycles and pin pacing.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge core_clk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		chk(32'(rresp), 32'(er));
	endtask : rd
	task automatic rc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d, RESP_OKAY);
		chk(d, exp);
	endtask : rc
	// Drives the same level on pin 0, channel 1 line A and channel 0 line B, then lets it settle.
	task automatic ext(input logic v);
		clock_pin[0] <= v;
		io_line_a[1] <= v;
		io_line_b[0] <= v;
		repeat (4) @(posedge core_clk);
	endtask : ext
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [31:0] v;
		logic [31:0] u;
		int k;
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (zoff[i]) rc(ad(1, 2, zoff[i]), 32'h0);
		rc(ad(0, 0, OFF_BCR), 32'h0);
		wr(ad(0, 0, 8'hC8), 32'h1, RESP_SLVERR);
		rd(32'hFFFD0100, v, RESP_SLVERR);
		// Random mode words on all six channels must not alias one another.
		for (int i = 0; i < 6; i++) begin
			ma[i] = mmask(rnd());
			wr(ad(i / 3, i % 3, OFF_CMR), ma[i], RESP_OKAY);
		end
		for (int i = 0; i < 6; i++) rc(ad(i / 3, i % 3, OFF_CMR), ma[i]);
		v = rnd() & 32'h3F;
		wr(ad(1, 0, OFF_BMR), v, RESP_OKAY);
		rc(ad(1, 0, OFF_BMR), v);
		// External line 0 from pin, channel 1 line A, idle channel 2 line A, nothing.
		for (int i = 0; i < 4; i++) begin
			k = 1 + int'(rnd() % 8);
			wr(ad(0, 0, OFF_BMR), 32'(routes[i]), RESP_OKAY);
			wr(ad(0, 0, OFF_CMR), 32'h5 | 32'(i % 2) << CMR_EDGE_INV, RESP_OKAY);
			wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
			repeat (k) begin
				ext(1'b1);
				ext(1'b0);
			end
			ext(1'b1);
			rc(ad(0, 0, OFF_CV), ext_cnt(i, k));
			ext(1'b0);
		end
		// Gated by a line that routes nowhere, the counter never moves.
		wr(ad(0, 0, OFF_CMR), 32'h10, RESP_OKAY);
		wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
		repeat (20) @(posedge core_clk);
		rc(ad(0, 0, OFF_CV), 32'h0);
		// Run, then disable, then enable and disable in one write.
		wr(ad(0, 0, OFF_CMR), 32'h0, RESP_OKAY);
		wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
		rd(ad(0, 0, OFF_SR), v, RESP_OKAY);
		chk(v & 32'h10000, 32'h10000);
		wr(ad(0, 0, OFF_CCR), 32'h2, RESP_OKAY);
		rd(ad(0, 0, OFF_CV), v, RESP_OKAY);
		chk(32'(v != 32'h0), 32'h1);
		wr(ad(0, 0, OFF_CCR), 32'h3, RESP_OKAY);
		repeat (10) @(posedge core_clk);
		rc(ad(0, 0, OFF_CV), v);
		rd(ad(0, 0, OFF_SR), u, RESP_OKAY);
		chk(u & 32'h10000, 32'h0);
		wr(ad(0, 0, OFF_BCR), 32'h0, RESP_OKAY);
		rc(ad(0, 0, OFF_CV), v);
		wr(ad(0, 0, OFF_BCR), 32'h1, RESP_OKAY);
		rc(ad(0, 0, OFF_CV), 32'h0);
		// Trigger edge codes on line B, then line A selected while B toggles.
		for (int i = 0; i < 5; i++) begin
			wr(ad(0, 0, OFF_CMR), 32'(i % 4 + i / 4 * 3) << 8 | 32'(i / 4) << 10, RESP_OKAY);
			wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
			repeat (10) @(posedge core_clk);
			wr(ad(0, 0, OFF_CCR), 32'h2, RESP_OKAY);
			rd(ad(0, 0, OFF_SR), v, RESP_OKAY);
			ext(1'b1);
			ext(1'b0);
			rd(ad(0, 0, OFF_CV), v, RESP_OKAY);
			chk(32'(v == 32'h0), 32'(i > 0 && i < 4));
			rd(ad(0, 0, OFF_SR), v, RESP_OKAY);
			chk(v & 32'h20, (i > 0 && i < 4) ? 32'h20 : 32'h0);
		end
		// Capture A on rise, B on fall, with disable on the second load.
		wr(ad(0, 0, OFF_CMR), 32'h00090080, RESP_OKAY);
		wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
		repeat (10) @(posedge core_clk);
		io_line_a[0] <= 1'b1;
		repeat (10) @(posedge core_clk);
		io_line_a[0] <= 1'b0;
		repeat (10) @(posedge core_clk);
		rd(ad(0, 0, OFF_SR), v, RESP_OKAY);
		chk(v & 32'h1001A, 32'h18);
		rd(ad(0, 0, OFF_RA), v, RESP_OKAY);
		rd(ad(0, 0, OFF_RB), u, RESP_OKAY);
		chk(32'(u > v && v != 32'h0), 32'h1);
		rc(ad(0, 0, OFF_CV), u);
		wr(ad(0, 0, OFF_RA), 32'h1234, RESP_OKAY);
		rc(ad(0, 0, OFF_RA), v);
		wr(ad(0, 0, OFF_CMR), 32'h8000, RESP_OKAY);
		wr(ad(0, 0, OFF_RA), 32'h1234, RESP_OKAY);
		rc(ad(0, 0, OFF_RA), 32'h1234);
		// Period match at three keeps the counter from passing three.
		wr(ad(0, 0, OFF_CMR), 32'h4000, RESP_OKAY);
		wr(ad(0, 0, OFF_RC), 32'h3, RESP_OKAY);
		wr(ad(0, 0, OFF_CCR), 32'h5, RESP_OKAY);
		repeat (6) begin
			rd(ad(0, 0, OFF_CV), v, RESP_OKAY);
			chk(32'(v <= 32'h3), 32'h1);
		end
		rd(ad(0, 0, OFF_SR), v, RESP_OKAY);
		chk(v & 32'h4, 32'h4);
		end_sim();
	end
endmodule : timer_counter_control_interface_test
`default_nettype wire
